// File: bench/cilh_checker.sv
// Checker: port properties of the current loss hold block
`timescale 1ns/1ps
module cilh_checker #(
  parameter int FW = 16 // Frequency word width
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [15:0] cur_t2_ua, // Current 2
  input wire logic [15:0] cur_t4_ua, // Current 4
  input wire cilh_pkg::cilh_drive_in_t drv, // Drive status
  input wire logic input_loss_flag, // Loss flag
  input wire logic [FW-1:0] freq_cmd, // Frequency
  input wire logic comp_enable, // Compensation
  input wire logic pid_run, // Loop running
  input wire logic pid_selected // Loop selected
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic chk_q, t2_q, wr_ctrl, lo;
  logic [5:0] low_q;
  logic [15:0] cur;
  assign cur = t2_q ? cur_t2_ua : cur_t4_ua;
  assign wr_ctrl = psel && penable && pwrite && paddr == cilh_pkg::CTRL_OFF;
  // Low current while checking and running forward; a stop input breaks the run
  assign lo = chk_q && cur <= cilh_pkg::TRIP_UA_RST && drv.fwd_run &&
      !drv.output_stop;
  // Control shadow, taken at the APB write edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q <= 1'b0;
      t2_q <= 1'b0;
    end else if (wr_ctrl) begin
      chk_q <= pwdata[0];
      t2_q <= pwdata[1];
    end
  end
  // Saturating count, so only the first tick window is judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q <= 6'h00;
    end else if (!lo) begin
      low_q <= 6'h00;
    end else if (low_q != 6'h3F) begin
      low_q <= low_q + 6'h01;
    end
  end
  a_flag_sets_low:
    assert property (low_q == 6'h2A |-> input_loss_flag)
    else $error("flag missing after low current");
  a_rise_needs_low:
    assert property ($rose(input_loss_flag) |->
      $past(cur) <= cilh_pkg::TRIP_UA_RST)
    else $error("flag rose on high raw sample");
  a_off_no_flag:
    assert property (!chk_q && !input_loss_flag |=> !input_loss_flag)
    else $error("flag set with checking off");
  a_run_off_zero:
    assert property (input_loss_flag && !drv.fwd_run && !drv.rev_run ##1
      input_loss_flag && !drv.jog && !drv.multi_speed && !drv.bypass &&
      !drv.process_loop_sel |=> freq_cmd == '0)
    else $error("output running without run command");
  a_stop_zero:
    assert property (drv.output_stop |=> freq_cmd == '0)
    else $error("output not shut off by stop input");
  a_comp_off:
    assert property (input_loss_flag && $past(input_loss_flag) |-> !comp_enable)
    else $error("compensation active during loss");
  a_loop_paused:
    assert property (input_loss_flag && $past(input_loss_flag) |-> !pid_run)
    else $error("process loop running during loss");
  a_loop_seen:
    assert property (drv.process_loop_sel ##1 drv.process_loop_sel |->
      pid_selected)
    else $error("process loop selection lost");
  c_loss: cover property ($rose(input_loss_flag));
  c_multi: cover property (input_loss_flag && drv.multi_speed);
  c_stop: cover property (input_loss_flag && drv.output_stop);
endmodule

// File: bench/cilh_top_tb.sv
// Testbench: loss detection, hold, priority and register access
`timescale 1ns/1ps
module cilh_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic flag, comp_en, pid_run, pid_sel;
  logic trav, pump, pfd, rfwd, rpend, rcmd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] pins;
  logic [15:0] t2_ua, t4_ua, filt, live, mfreq, fcmd, jfreq;
  logic [15:0] tgt [2];
  cilh_pkg::cilh_drive_in_t drv;
  int fails, comparisons, cyc, hold;
  cilh_xmtr fast_inst (.clk(pclk), .target_ua(tgt[0]), .step_ua(16'h01F4),
    .cur_ua(t4_ua));
  cilh_xmtr slow_inst (.clk(pclk), .target_ua(tgt[1]), .step_ua(16'h0014),
    .cur_ua(t2_ua));
  cilh_top cilh_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cur_t2_ua(t2_ua),
    .cur_t4_ua(t4_ua), .filt_freq(filt), .live_freq(live),
    .base_freq(16'h0000), .multi_freq(mfreq), .jog_freq(jfreq),
    .panel_freq(16'h0000), .panel_mode(1'b0), .remote_cmd(rcmd), .drv(drv),
    .input_loss_flag(flag), .out_pins(pins), .freq_cmd(fcmd), .run_fwd(rfwd),
    .run_rev(), .comp_enable(comp_en), .pid_run(pid_run),
    .pid_selected(pid_sel), .traverse_hold(trav), .pump_enable(pump),
    .pf_decel(pfd), .remote_pending(rpend));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic clk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; the request stands until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wait_flag(input logic v);
    for (int i = 0; i < 200 && flag !== v; i++) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: roughly twice the few thousand cycles the tests need
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails++;
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, filt, live, mfreq} = '0;
    {jfreq, rcmd} = '0;
    drv = 10'h200;
    tgt[0] = 16'h4E20;
    tgt[1] = 16'h4E20;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    presetn = 1'b0;
    void'($urandom(29));
    clk(10);
    presetn <= 1'b1;
    apb(1'b0, cilh_pkg::CTRL_OFF, 32'h0);
    check(rd, cilh_pkg::CTRL_RST);
    check(flag, 1'b0);
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    check(err, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h00000000);
    // Even passes watch input 4 (fast loop), odd ones input 2 (slow loop)
    for (int k = 0; k < 4; k++) begin
      presetn <= 1'b0;
      drv <= 10'h200;
      clk(2);
      presetn <= 1'b1;
      tgt[k % 2] <= 16'h03E8;
      apb(1'b1, cilh_pkg::CTRL_OFF, 32'(2 * (k % 2)));
      // Long enough for the slow loop to come down from full scale
      clk(1000);
      check(flag, 1'b0);
      hold = $urandom_range(60000, 100);
      filt <= 16'(hold);
      tgt[k % 2] <= 16'h07D0;
      clk(60);
      apb(1'b1, cilh_pkg::CTRL_OFF, 32'(2 * (k % 2) + 1));
      wait_flag(1'b1);
      check(flag, 1'b1);
      filt <= ~filt;
      live <= 16'($urandom_range(60000, 100));
      drv.process_loop_sel <= 1'b1;
      drv.pump_switch <= 1'b1;
      clk(3);
      check(fcmd, hold);
      check({comp_en, pid_run, pid_sel}, 3'h1);
      check(trav, 1'b1);
      check(pump, 1'b1);
      drv.process_loop_sel <= 1'b0;
      apb(1'b1, cilh_pkg::MINF_OFF, hold + 1);
      clk(3);
      check(fcmd, hold + 1);
      apb(1'b1, cilh_pkg::MINF_OFF, 32'h0);
      apb(1'b1, cilh_pkg::PINSEL_OFF, cilh_pkg::FUNC_LOSS_POS);
      clk(3);
      check(pins[0], 1'b1);
      apb(1'b1, cilh_pkg::PINSEL_OFF, cilh_pkg::FUNC_LOSS_NEG);
      clk(3);
      check(pins[0], 1'b0);
      case (k)
        0: begin
          rcmd <= 1'b1;
          clk(1);
          rcmd <= 1'b0;
          clk(3);
          check({rpend, fcmd}, {1'b1, 16'(hold)});
          jfreq <= 16'($urandom_range(60000, 100));
          drv.jog <= 1'b1;
          clk(3);
          check(fcmd, jfreq);
          drv.jog <= 1'b0;
          clk(3);
          check(fcmd, 0);
          tgt[0] <= 16'h0BB8;
          clk(100);
          check(flag, 1'b1);
          tgt[0] <= 16'h0BB9;
          wait_flag(1'b0);
          clk(3);
          check({flag, fcmd}, {1'b0, live});
          check(rpend, 1'b0);
        end
        1: begin
          mfreq <= 16'($urandom_range(60000, 100));
          drv.multi_speed <= 1'b1;
          clk(3);
          check(fcmd, mfreq);
          drv.multi_speed <= 1'b0;
          clk(3);
          check(fcmd, 0);
        end
        2: begin
          drv.output_stop <= 1'b1;
          clk(3);
          drv.output_stop <= 1'b0;
          clk(3);
          check(fcmd, 0);
        end
        default: begin
          drv.undervolt <= 1'b1;
          clk(3);
          check({pfd, fcmd}, {1'b1, 16'h0000});
          drv.undervolt <= 1'b0;
          apb(1'b1, cilh_pkg::CTRL_OFF, 32'(2 * (k % 2) + 9));
          clk(3);
          check(rfwd, 1'b0);
          drv.fwd_run <= 1'b0;
          clk(3);
          check(fcmd, 0);
          drv.fwd_run <= 1'b1;
          clk(3);
          check(fcmd == 16'(hold), 1'b0);
        end
      endcase
      $display("Test %0d done", k);
    end
    give_verdict();
  end
endmodule
bind cilh_top cilh_checker #(.FW(FW)) cilh_checker_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .cur_t2_ua(cur_t2_ua),
  .cur_t4_ua(cur_t4_ua), .drv(drv), .input_loss_flag(input_loss_flag),
  .freq_cmd(freq_cmd), .comp_enable(comp_enable), .pid_run(pid_run),
  .pid_selected(pid_selected));

// File: bench/cilh_xmtr.sv
// Partner: current transmitter loop with a limited slew rate
`timescale 1ns/1ps
module cilh_xmtr (
  input wire logic clk, // Sample clock
  input wire logic [15:0] target_ua, // Demanded loop current
  input wire logic [15:0] step_ua, // Slew per clock, prompt or slow
  output logic [15:0] cur_ua // Loop current seen by the drive
);
  int c = 20000;
  // A real loop cannot jump, so the current ramps to the target
  always @(posedge clk) begin
    if (c + step_ua < target_ua) c <= c + step_ua;
    else if (c > target_ua + step_ua) c <= c - step_ua;
    else c <= target_ua;
  end
  assign cur_ua = 16'(c);
endmodule

// File: common/cilh_pkg.sv
// Package for the current-input loss hold block: register map and types
package cilh_pkg;

  // Register byte offsets (APB, one aligned word each)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PINSEL_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] HOLD_OFF = 8'h0C;
  localparam logic [7:0] FOUT_OFF = 8'h10;
  localparam logic [7:0] MINF_OFF = 8'h14;
  localparam logic [7:0] THR_OFF = 8'h18;

  // Control register field positions
  localparam int CTRL_CHECK_BIT = 0;
  localparam int CTRL_TERM_BIT = 1;
  localparam int CTRL_REVPROH_BIT = 2;
  localparam int CTRL_FWDPROH_BIT = 3;

  // Output pin function codes for the loss flag
  localparam logic [7:0] FUNC_LOSS_POS = 8'd98;
  localparam logic [7:0] FUNC_LOSS_NEG = 8'd198;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [7:0] PINSEL_RST = 8'h00;
  localparam logic [15:0] MINF_RST = 16'h0000;
  // Current codes in uA: trip at 2 mA, release above 3 mA
  localparam logic [15:0] TRIP_UA_RST = 16'd2000;
  localparam logic [15:0] REL_UA_RST = 16'd3000;

  // Sample period of the control loop
  localparam int SAMPLE_US = 1;
  localparam int CLK_MHZ = 40;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;

  // Speed source selected by priority
  typedef enum logic [2:0] {
    SRC_STOP = 3'b000,
    SRC_LIVE = 3'b001,
    SRC_HOLD = 3'b010,
    SRC_MULTI = 3'b011,
    SRC_JOG = 3'b100,
    SRC_BYPASS = 3'b101
  } cilh_src_t;

  // Loss state machine
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_LOST = 2'b01,
    ST_STOPPED = 2'b10
  } cilh_state_t;

  // Drive status inputs bundled
  typedef struct packed {
    logic fwd_run;
    logic rev_run;
    logic multi_speed;
    logic jog;
    logic output_stop;
    logic undervolt;
    logic retry_ok;
    logic bypass;
    logic pump_switch;
    logic process_loop_sel;
  } cilh_drive_in_t;

endpackage

// File: design/cilh_top.sv
// Current-input loss detection, frequency hold and source priority
// Behaviour
// - Loss check on: flag sets when raw current is at or below 2 mA
// - Loss check off: no detection, flag never set
// - On detection latch filtered frequency and run at it
// - Flag clears and live command resumes above 3 mA, or when loss check is turned off
// - Flag routable to output pin, code 98 true, 198 inverted
// - Dropping run command discards the held frequency
// - Detection fires regardless of bias calibration setting
// - Minimum frequency clamp still applies during loss
// - Multi-speed overrides hold during loss; stop when it drops
// - Jog overrides hold during loss; stop when released
// - Output stop shuts output; during loss stays stopped after release
// - Remote up/down/clear during loss leave hold untouched
// - Successful retry during loss keeps the held frequency
// - Auxiliary and override compensation disabled during loss
// - Compare raw sample; latch post-filter average frequency
// - Process loop suspended during loss, selection still seen
// - Panel and jog stay allowed under process loop, win over hold
// - Traverse uses held frequency as centre during loss
// - Bypass uses hold; disabling check there stops next latch
// - Auxiliary pump switching still acts during loss
// - Undervoltage during loss stops by power-failure decel
// - Direction restriction applies regardless of loss check
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module cilh_top #(
  parameter int FW = 16 // Frequency word width
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  input wire logic [15:0] cur_t2_ua, // Raw current, input 2, uA
  input wire logic [15:0] cur_t4_ua, // Raw current, input 4, uA
  input wire logic [FW-1:0] filt_freq, // Post-filter averaged frequency
  input wire logic [FW-1:0] live_freq, // Live command incl compensation
  input wire logic [FW-1:0] base_freq, // Live command, no compensation
  input wire logic [FW-1:0] multi_freq, // Multi-speed frequency
  input wire logic [FW-1:0] jog_freq, // Jog frequency
  input wire logic [FW-1:0] panel_freq, // Operator panel frequency
  input wire logic panel_mode, // Operator panel operation active
  input wire logic remote_cmd, // Remote up/down/clear pulse
  input wire cilh_pkg::cilh_drive_in_t drv, // Drive status inputs
  output logic input_loss_flag, // Loss flag, registered
  output logic [6:0] out_pins, // Output terminals
  output logic [FW-1:0] freq_cmd, // Selected output frequency
  output logic run_fwd, // Forward rotation enable
  output logic run_rev, // Reverse rotation enable
  output logic comp_enable, // Aux and override compensation on
  output logic pid_run, // Process loop computation running
  output logic pid_selected, // Process loop selection seen
  output logic traverse_hold, // Traverse centre is held frequency
  output logic pump_enable, // Auxiliary pump switching allowed
  output logic pf_decel, // Power-failure deceleration request
  output logic remote_pending // Remote command waits restoration
);

  cilh_pkg::cilh_state_t state_q, state_d;
  cilh_pkg::cilh_src_t src;
  logic [31:0] ctrl_q;
  logic [7:0] pinsel_q [7];
  logic [15:0] minf_q, trip_q, rel_q;
  logic [FW-1:0] hold_q, fsel;
  logic hold_valid_q, bypass_block_q, stop_latch_q, remote_q;
  logic [5:0] tick_q;
  logic tick, check_en, run, cur_low, cur_ok;
  logic [15:0] cur_raw;
  logic wr, rd_hit;
  logic [2:0] pidx;

  // Clamp a frequency to the minimum
  function automatic logic [FW-1:0] clamp_min(input logic [FW-1:0] f,
      input logic [15:0] m);
    logic [FW-1:0] mm;
    mm = FW'(m);
    clamp_min = (f < mm) ? mm : f;
  endfunction

  assign check_en = ctrl_q[cilh_pkg::CTRL_CHECK_BIT];
  assign run = drv.fwd_run | drv.rev_run;
  assign cur_raw = ctrl_q[cilh_pkg::CTRL_TERM_BIT] ? cur_t2_ua : cur_t4_ua;
  // Raw sample, ignores bias setting and filter
  assign cur_low = cur_raw <= trip_q;
  assign cur_ok = cur_raw > rel_q;

  // Sample tick divides the clock to the control period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= '0;
    end else if (tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 6'd1;
    end
  end
  assign tick = (tick_q == 6'(cilh_pkg::SAMPLE_CYC - 1));

  // Loss state: flag set on low, cleared above release level
  always_comb begin
    state_d = state_q;
    case (state_q)
      cilh_pkg::ST_NORMAL: begin
        if (check_en && cur_low) begin
          state_d = cilh_pkg::ST_LOST;
        end
      end
      cilh_pkg::ST_LOST, cilh_pkg::ST_STOPPED: begin
        if (!check_en) begin
          state_d = cilh_pkg::ST_NORMAL;
        end else if (cur_ok) begin
          state_d = cilh_pkg::ST_NORMAL;
        end else if (drv.output_stop || drv.undervolt) begin
          state_d = cilh_pkg::ST_STOPPED;
        end else if (!run) begin
          state_d = cilh_pkg::ST_STOPPED;
        end
      end
      default: state_d = cilh_pkg::ST_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cilh_pkg::ST_NORMAL;
    end else if (tick) begin
      state_q <= state_d;
    end
  end
  assign input_loss_flag = (state_q != cilh_pkg::ST_NORMAL);

  // Held frequency: latched at entry, kept across retry, dropped on stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= '0;
      hold_valid_q <= 1'b0;
    end else if (!run) begin
      hold_q <= '0;
      hold_valid_q <= 1'b0;
    end else if (input_loss_flag && (drv.multi_speed || drv.jog)) begin
      // An override during loss forgets the hold, so its release stops
      hold_valid_q <= 1'b0;
    end else if (tick && state_q == cilh_pkg::ST_NORMAL &&
        state_d == cilh_pkg::ST_LOST) begin
      // Multi-speed, jog or blocked bypass latch nothing
      if (!drv.multi_speed && !drv.jog && !bypass_block_q) begin
        hold_q <= filt_freq;
        hold_valid_q <= 1'b1;
      end
    end
    // Retry does not touch the hold; it simply carries on
  end

  // Check disabled while bypassed blocks the next latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_block_q <= 1'b0;
    end else if (drv.bypass && !check_en) begin
      bypass_block_q <= 1'b1;
    end else if (!drv.bypass && check_en) begin
      bypass_block_q <= 1'b0;
    end
  end

  // Output stop latch: remains stopped after release during loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_latch_q <= 1'b0;
    end else if (!input_loss_flag || !run) begin
      stop_latch_q <= 1'b0;
    end else if (drv.output_stop) begin
      stop_latch_q <= 1'b1;
    end
  end

  // Remote commands wait until current is restored; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remote_q <= 1'b0;
    end else if (remote_cmd && input_loss_flag) begin
      remote_q <= 1'b1;
    end else if (!input_loss_flag) begin
      remote_q <= 1'b0;
    end
  end
  assign remote_pending = remote_q;

  // Source priority
  always_comb begin
    src = cilh_pkg::SRC_LIVE;
    if (drv.output_stop || stop_latch_q || drv.undervolt) begin
      src = cilh_pkg::SRC_STOP;
    end else if (!input_loss_flag) begin
      src = drv.jog ? cilh_pkg::SRC_JOG :
            drv.multi_speed ? cilh_pkg::SRC_MULTI : cilh_pkg::SRC_LIVE;
    end else if (drv.jog || (panel_mode && drv.process_loop_sel)) begin
      src = cilh_pkg::SRC_JOG;
    end else if (drv.multi_speed) begin
      src = cilh_pkg::SRC_MULTI;
    end else if (hold_valid_q && drv.bypass) begin
      src = cilh_pkg::SRC_BYPASS;
    end else if (hold_valid_q && state_q == cilh_pkg::ST_LOST) begin
      src = cilh_pkg::SRC_HOLD;
    end else begin
      src = cilh_pkg::SRC_STOP;
    end
  end

  always_comb begin
    case (src)
      cilh_pkg::SRC_LIVE: fsel = live_freq;
      cilh_pkg::SRC_HOLD: fsel = hold_q;
      cilh_pkg::SRC_BYPASS: fsel = hold_q;
      cilh_pkg::SRC_MULTI: fsel = multi_freq;
      cilh_pkg::SRC_JOG: fsel = drv.jog ? jog_freq : panel_freq;
      default: fsel = '0;
    endcase
  end

  // Registered frequency and mode outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd <= '0;
      run_fwd <= 1'b0;
      run_rev <= 1'b0;
      comp_enable <= 1'b1;
      pid_run <= 1'b0;
      pid_selected <= 1'b0;
      traverse_hold <= 1'b0;
      pump_enable <= 1'b0;
      pf_decel <= 1'b0;
    end else begin
      // Clamp applies to every running source, not to stop
      freq_cmd <= (src == cilh_pkg::SRC_STOP) ? '0 :
                  clamp_min(fsel, minf_q);
      // Direction restriction is independent of the check
      run_fwd <= drv.fwd_run &
                 !ctrl_q[cilh_pkg::CTRL_FWDPROH_BIT];
      run_rev <= drv.rev_run &
                 !ctrl_q[cilh_pkg::CTRL_REVPROH_BIT];
      comp_enable <= !input_loss_flag;
      pid_run <= drv.process_loop_sel & !input_loss_flag;
      pid_selected <= drv.process_loop_sel;
      traverse_hold <= input_loss_flag & hold_valid_q;
      pump_enable <= drv.pump_switch;
      pf_decel <= drv.undervolt;
    end
  end

  // Output pins: each may carry the loss flag in either sense
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_pins <= '0;
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (pinsel_q[i] == cilh_pkg::FUNC_LOSS_POS) begin
          out_pins[i] <= input_loss_flag;
        end else if (pinsel_q[i] == cilh_pkg::FUNC_LOSS_NEG) begin
          out_pins[i] <= !input_loss_flag;
        end else begin
          out_pins[i] <= 1'b0;
        end
      end
    end
  end

  // APB slave: zero wait states, error on unmapped address
  assign wr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign pidx = paddr[4:2];
  assign rd_hit = (paddr <= cilh_pkg::THR_OFF) && (paddr[1:0] == 2'b00);
  assign pslverr = psel & penable & !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= cilh_pkg::CTRL_RST;
      minf_q <= cilh_pkg::MINF_RST;
      trip_q <= cilh_pkg::TRIP_UA_RST;
      rel_q <= cilh_pkg::REL_UA_RST;
      for (int i = 0; i < 7; i++) begin
        pinsel_q[i] <= cilh_pkg::PINSEL_RST;
      end
    end else if (wr && rd_hit) begin
      case (paddr)
        cilh_pkg::CTRL_OFF: ctrl_q <= {28'h0000000, pwdata[3:0]};
        cilh_pkg::PINSEL_OFF: begin
          // Pin select word: index in [10:8], code in [7:0]
          if (pwdata[10:8] < 3'd7) begin
            pinsel_q[pwdata[10:8]] <= pwdata[7:0];
          end
        end
        cilh_pkg::MINF_OFF: minf_q <= pwdata[15:0];
        cilh_pkg::THR_OFF: begin
          trip_q <= pwdata[15:0];
          rel_q <= pwdata[31:16];
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      cilh_pkg::CTRL_OFF: prdata = ctrl_q;
      cilh_pkg::PINSEL_OFF: prdata = {24'h000000, pinsel_q[0]};
      cilh_pkg::STAT_OFF: prdata = {26'h0000000, remote_q, stop_latch_q,
          hold_valid_q, state_q, input_loss_flag};
      cilh_pkg::HOLD_OFF: prdata = 32'(hold_q);
      cilh_pkg::FOUT_OFF: prdata = 32'(freq_cmd);
      cilh_pkg::MINF_OFF: prdata = {16'h0000, minf_q};
      cilh_pkg::THR_OFF: prdata = {rel_q, trip_q};
      default: prdata = 32'h00000000;
    endcase
  end

  logic unused_ok;
  assign unused_ok = &{1'b0, base_freq, drv.retry_ok, pidx};

endmodule
